// *** dv/fault_pin_and_input_status_bench.sv ***
`include "fpis_defs.svh"
module fault_pin_and_input_status_bench
	import fpis_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0, rst_b_in = 1'b0, od_wr_in = 1'b0, od_rd_in = 1'b0, out_cmd_writable_in = 1'b1;
	logic target_reached_in = 1'b0, position_start_in = 1'b0, sw_drive = 1'b0, sw_level = 1'b0, ev;
	logic [15:0]  od_index_in = 16'h0000, od_wdata_in = 16'h0000, od_rdata_out, rv;
	logic [7:0]   od_sub_in = 8'h00, error_flags_in = 8'h00;
	logic [4:0]   input_levels_in = 5'h00, switch_polarity_in = 5'h1F, input_logical_out;
	logic [127:0] raw_codes_in;
	logic [79:0]  mv_codes_in = {64'h0, 16'hFC18};
	logic [63:0]  temp_words_in = 64'h0040_0030_0020_0010;
	logic od_ack_out, od_err_out, fault_pin_in, fault_pin_out, fault_pin_oe_out, fault_ref_input_out, fault_limit_valid_out;
	int n_mismatch = 0;
	int tests_run = 0;
	fpis_top u_fpis_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .od_wr_in(od_wr_in), .od_rd_in(od_rd_in),
		.od_index_in(od_index_in), .od_sub_in(od_sub_in), .od_wdata_in(od_wdata_in), .od_rdata_out(od_rdata_out),
		.od_ack_out(od_ack_out), .od_err_out(od_err_out), .fault_pin_in(fault_pin_in), .fault_pin_out(fault_pin_out),
		.fault_pin_oe_out(fault_pin_oe_out), .input_levels_in(input_levels_in), .switch_polarity_in(switch_polarity_in),
		.out_cmd_writable_in(out_cmd_writable_in), .error_flags_in(error_flags_in), .target_reached_in(target_reached_in),
		.position_start_in(position_start_in), .raw_codes_in(raw_codes_in), .mv_codes_in(mv_codes_in),
		.temp_words_in(temp_words_in), .fault_ref_input_out(fault_ref_input_out),
		.fault_limit_valid_out(fault_limit_valid_out), .input_logical_out(input_logical_out));
	fpis_pin_model u_fpis_pin_model (.oe_in(fault_pin_oe_out), .drive_in(sw_drive), .level_in(sw_level),
		.pin_out(fault_pin_in));
	always #20 clk_in = ~clk_in;
	// raw word k carries 0x8000 plus its subindex, a negative reading
	initial for (int k = 0; k < 8; k++) raw_codes_in[16*k +: 16] = 16'h8000 | 16'(k + 1);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one access: strobe for one edge, answer looked at one edge later
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [15:0] d);
		@(posedge clk_in);
		od_wr_in <= w;
		od_rd_in <= ~w;
		od_index_in <= i;
		od_sub_in <= s;
		od_wdata_in <= d;
		@(posedge clk_in);
		od_wr_in <= 1'b0;
		od_rd_in <= 1'b0;
		#1;
		chk(16'(od_ack_out), 16'h0001);
		rv = od_rdata_out;
		ev = od_err_out;
	endtask
	// bounded wait for the pin pull to reach a level
	task automatic wait_oe(input logic e, input int lim);
		int k;
		k = 0;
		#1;
		while (fault_pin_oe_out !== e && k < lim) begin
			@(posedge clk_in);
			#1;
			k++;
		end
		chk(16'(fault_pin_oe_out), 16'(e));
	endtask
	task automatic flags(input logic [7:0] v);
		@(posedge clk_in);
		error_flags_in <= v;
	endtask
	task automatic t_objects;
		logic [15:0] ix [5] = '{`FPIS_IDX_PIN_CFG, `FPIS_IDX_INPUT_STATE, `FPIS_IDX_ANALOG_MV, `FPIS_IDX_ANALOG_RAW,
			`FPIS_IDX_TEMP_STATUS};
		logic [15:0] nx [5] = '{16'h0003, 16'h0004, 16'h0005, 16'h0008, 16'h0004};
		for (int k = 0; k < 5; k++) begin
			acc(1'b0, ix[k], 8'h00, 16'h0000);
			chk(rv, nx[k]);
			acc(1'b1, ix[k], 8'h01, 16'h0001);
			chk(16'(ev), 16'h0001);
		end
		acc(1'b0, `FPIS_IDX_PIN_CFG, `FPIS_SUB_ROLE, 16'h0000);
		chk(rv, 16'h0000);
		for (int k = 1; k < 9; k++) begin
			acc(1'b0, `FPIS_IDX_ANALOG_RAW, 8'(k), 16'h0000);
			chk(rv, 16'h8000 | 16'(k));
		end
		for (int k = 1; k < 5; k++) begin
			acc(1'b0, `FPIS_IDX_TEMP_STATUS, 8'(k), 16'h0000);
			chk(rv, 16'(k * 16));
		end
		acc(1'b0, `FPIS_IDX_ANALOG_MV, 8'h01, 16'h0000);
		chk(rv, 16'hFC18);
		acc(1'b0, 16'h1234, 8'h00, 16'h0000);
		chk(16'(ev), 16'h0001);
	endtask
	task automatic t_error;
		flags(8'h08);
		wait_oe(1'b1, 4);
		flags(8'h00);
		wait_oe(1'b0, 4);
		acc(1'b1, `FPIS_IDX_ERR_CFG, `FPIS_SUB_ERR_MASK, 16'h00F7);
		acc(1'b0, `FPIS_IDX_ERR_CFG, `FPIS_SUB_ERR_MASK, 16'h0000);
		chk(rv, 16'h00F7);
		flags(8'h08);
		repeat (8) @(posedge clk_in);
		#1;
		chk(16'(fault_pin_oe_out), 16'h0000);
		acc(1'b1, `FPIS_IDX_ERR_DELAY, `FPIS_SUB_ERR_DELAY, 16'h0002);
		acc(1'b0, `FPIS_IDX_ERR_DELAY, `FPIS_SUB_ERR_DELAY, 16'h0000);
		chk(rv, 16'h0002);
		flags(8'h01);
		repeat (249000) @(posedge clk_in);
		#1;
		chk(16'(fault_pin_oe_out), 16'h0000);
		wait_oe(1'b1, 251100);
		flags(8'h00);
		wait_oe(1'b0, 8);
		acc(1'b1, `FPIS_IDX_ERR_DELAY, `FPIS_SUB_ERR_DELAY, 16'h0000);
		flags(8'h02);
		wait_oe(1'b1, 4);
		flags(8'h00);
		wait_oe(1'b0, 8);
		acc(1'b1, `FPIS_IDX_ERR_CFG, `FPIS_SUB_ERR_MASK, 16'h00FF);
	endtask
	task automatic t_output;
		logic [7:0] cm [4] = '{FPIS_CMD_SET, FPIS_CMD_TOGGLE, FPIS_CMD_TOGGLE, FPIS_CMD_CLEAR};
		logic oe [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		acc(1'b1, `FPIS_IDX_PIN_CFG, `FPIS_SUB_ROLE, 16'(FPIS_ROLE_OUTPUT));
		wait_oe(1'b1, 3);
		for (int k = 0; k < 4; k++) begin
			acc(1'b1, `FPIS_IDX_PIN_CFG, `FPIS_SUB_OUT_CMD, 16'(cm[k]));
			wait_oe(oe[k], 3);
		end
		acc(1'b0, `FPIS_IDX_PIN_CFG, `FPIS_SUB_OUT_CMD, 16'h0000);
		chk(rv, 16'h0000);
		acc(1'b1, `FPIS_IDX_PIN_CFG, `FPIS_SUB_OUT_CMD, 16'h0003);
		chk(16'(ev), 16'h0001);
		out_cmd_writable_in <= 1'b0;
		acc(1'b1, `FPIS_IDX_PIN_CFG, `FPIS_SUB_OUT_CMD, 16'h0001);
		chk(16'(ev), 16'h0001);
		out_cmd_writable_in <= 1'b1;
		acc(1'b1, `FPIS_IDX_PIN_CFG, `FPIS_SUB_ROLE, 16'h0001);
		acc(1'b0, `FPIS_IDX_PIN_CFG, `FPIS_SUB_ROLE, 16'h0000);
		chk(rv, 16'h0002);
	endtask
	task automatic t_input;
		logic [4:0] ph, lg;
		logic e1;
		acc(1'b1, `FPIS_IDX_PIN_CFG, `FPIS_SUB_ROLE, 16'(FPIS_ROLE_REF_IN));
		wait_oe(1'b0, 3);
		sw_drive <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_in);
			sw_level <= k[0];
			switch_polarity_in <= k[1] ? 5'h0A : 5'h15;
			input_levels_in <= k[0] ? 5'h1D : 5'h0A;
			repeat (4) @(posedge clk_in);
			#1;
			ph = {input_levels_in[4:2], k[0], input_levels_in[0]};
			lg = ~(ph ^ switch_polarity_in);
			e1 = lg[1];
			chk(16'(fault_limit_valid_out), 16'h0001);
			chk(16'(fault_ref_input_out), 16'(e1));
			chk(16'(input_logical_out), 16'(lg));
			acc(1'b0, `FPIS_IDX_INPUT_STATE, `FPIS_SUB_PHYSICAL, 16'h0000);
			chk(rv, 16'(ph));
			acc(1'b0, `FPIS_IDX_INPUT_STATE, `FPIS_SUB_LOGICAL, 16'h0000);
			chk(rv, 16'(lg));
		end
		sw_drive <= 1'b0;
		acc(1'b1, `FPIS_IDX_PIN_CFG, `FPIS_SUB_ROLE, 16'(FPIS_ROLE_ERROR));
		@(posedge clk_in);
		#1;
		chk(16'(fault_limit_valid_out), 16'h0000);
	endtask
	task automatic t_target;
		acc(1'b1, `FPIS_IDX_PIN_CFG, `FPIS_SUB_ROLE, 16'(FPIS_ROLE_TARGET));
		repeat (3) @(posedge clk_in);
		#1;
		chk(16'(fault_pin_oe_out), 16'h0000);
		target_reached_in <= 1'b1;
		@(posedge clk_in);
		target_reached_in <= 1'b0;
		wait_oe(1'b1, 4);
		repeat (6) @(posedge clk_in);
		#1;
		chk(16'(fault_pin_oe_out), 16'h0001);
		position_start_in <= 1'b1;
		@(posedge clk_in);
		position_start_in <= 1'b0;
		wait_oe(1'b0, 4);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_objects;
		t_error;
		t_output;
		t_input;
		t_target;
		give_verdict;
	end
	// hang guard, well past the two long error-delay units
	initial begin
		#24000000;
		n_mismatch++;
		give_verdict;
	end
endmodule
bind fpis_top fpis_top_checker u_fpis_top_checker (.clk_in(clk_in), .rst_b_in(rst_b_in), .od_wr_in(od_wr_in),
	.od_rd_in(od_rd_in), .od_index_in(od_index_in), .od_sub_in(od_sub_in), .od_wdata_in(od_wdata_in),
	.od_rdata_out(od_rdata_out), .od_ack_out(od_ack_out), .od_err_out(od_err_out), .fault_pin_in(fault_pin_in),
	.fault_pin_out(fault_pin_out), .fault_pin_oe_out(fault_pin_oe_out), .input_levels_in(input_levels_in),
	.switch_polarity_in(switch_polarity_in), .fault_ref_input_out(fault_ref_input_out),
	.fault_limit_valid_out(fault_limit_valid_out), .input_logical_out(input_logical_out));

// *** dv/fpis_pin_model.sv ***
// outside circuit on the fault pin: pull-up plus a switch
module fpis_pin_model (
	input  wire logic oe_in,
	input  wire logic drive_in,
	input  wire logic level_in,
	output logic      pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// device pull wins; switch only drives when enabled, else pull-up
	assign pin_out = oe_in ? 1'b0 : (drive_in ? level_in : 1'b1);
endmodule

// *** dv/fpis_top_assertions.sv ***
`include "fpis_defs.svh"
// port-level watch on the fault pin block, bound from the bench
module fpis_top_checker (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        od_wr_in,
	input  wire logic        od_rd_in,
	input  wire logic [15:0] od_index_in,
	input  wire logic [7:0]  od_sub_in,
	input  wire logic [15:0] od_wdata_in,
	input  wire logic [15:0] od_rdata_out,
	input  wire logic        od_ack_out,
	input  wire logic        od_err_out,
	input  wire logic        fault_pin_in,
	input  wire logic        fault_pin_out,
	input  wire logic        fault_pin_oe_out,
	input  wire logic [4:0]  input_levels_in,
	input  wire logic [4:0]  switch_polarity_in,
	input  wire logic        fault_ref_input_out,
	input  wire logic        fault_limit_valid_out,
	input  wire logic [4:0]  input_logical_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	logic strobe; // any request on the port
	assign strobe = od_wr_in | od_rd_in;
	ack_after_strobe_a: assert property (strobe |=> od_ack_out)
		else $error("request not answered");
	ack_has_cause_a: assert property ($past(rst_b_in) && od_ack_out |-> $past(strobe))
		else $error("answer without request");
	err_with_ack_a: assert property (od_err_out |-> od_ack_out)
		else $error("refusal outside an answer");
	ro_write_refused_a: assert property (od_wr_in && (od_index_in inside {`FPIS_IDX_INPUT_STATE,
		`FPIS_IDX_ANALOG_MV, `FPIS_IDX_ANALOG_RAW, `FPIS_IDX_TEMP_STATUS}) |=> od_err_out)
		else $error("write to read-only word taken");
	bad_role_refused_a: assert property (od_wr_in && od_index_in == `FPIS_IDX_PIN_CFG && od_sub_in == `FPIS_SUB_ROLE
		&& !(od_wdata_in[7:0] inside {8'h00, 8'h02, 8'h04, 8'h05}) |=> od_err_out)
		else $error("undefined role taken");
	count_read_a: assert property (od_rd_in && !od_wr_in && od_index_in == `FPIS_IDX_PIN_CFG
		&& od_sub_in == `FPIS_SUB_COUNT |=> od_rdata_out == 16'h0003)
		else $error("pin entry count wrong");
	pin_open_collector_a: assert property (fault_pin_out == 1'b0)
		else $error("pin driven high");
	input_role_released_a: assert property (fault_limit_valid_out && $past(fault_limit_valid_out)
		|-> !fault_pin_oe_out) else $error("pin pulled in input role");
	logical_eval_a: assert property ($past(rst_b_in) && $stable(input_levels_in) && $stable(switch_polarity_in)
		|-> input_logical_out[0] == ~(input_levels_in[0] ^ switch_polarity_in[0])
		&& input_logical_out[4:2] == ~(input_levels_in[4:2] ^ switch_polarity_in[4:2]))
		else $error("logical inputs wrong");
	ref_eval_a: assert property (fault_limit_valid_out && $past(fault_limit_valid_out) && $stable(fault_pin_in)
		&& $stable(switch_polarity_in) |-> fault_ref_input_out == ~(fault_pin_in ^ switch_polarity_in[1]))
		else $error("reference input wrong");
	// main scenarios reached
	cover property (od_err_out);
	cover property ($rose(fault_pin_oe_out));
	cover property (fault_limit_valid_out);
endmodule

// *** verilog/fpis_bank.sv ***
`include "fpis_defs.svh"
// registered read-back of the analogue and temperature words
module fpis_bank
	import fpis_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	input  wire logic [127:0] raw_codes_in,
	input  wire logic [79:0]  mv_codes_in,
	input  wire logic [63:0]  temp_words_in,
	input  wire logic [15:0]  index_in,
	input  wire logic [7:0]   sub_in,
	output logic              hit_out,
	output logic [15:0]       data_out
);
	typedef struct packed {
		logic        hit;
		logic [15:0] data;
	} fpis_bank_state_t;
	fpis_bank_state_t s_r, s_nxt;

	// decode: subindex 0 is the entry count, others pick a word
	always_comb begin
		s_nxt = '{hit: 1'b0, data: 16'h0000};
		if (index_in == `FPIS_IDX_ANALOG_RAW) begin
			s_nxt.hit = (sub_in <= 8'h08);
			if (sub_in == `FPIS_SUB_COUNT) begin
				s_nxt.data = {8'h00, `FPIS_RAW_COUNT};
			end else if (sub_in <= 8'h08) begin
				// 3-bit wrap keeps subindex 8 on word 7 instead of underflowing
				s_nxt.data = raw_codes_in[{3'(sub_in[2:0] - 3'd1), 4'h0} +: 16];
			end
		end else if (index_in == `FPIS_IDX_ANALOG_MV) begin
			// subindex 2 is absent: the fault pin has no millivolt word
			s_nxt.hit = (sub_in <= 8'h05) && (sub_in != 8'h02);
			if (sub_in == `FPIS_SUB_COUNT) begin
				s_nxt.data = {8'h00, `FPIS_ANALOG_MV_COUNT};
			end else if (s_nxt.hit) begin
				s_nxt.data = mv_codes_in[{3'(sub_in[2:0] - 3'd1), 4'h0} +: 16];
			end
		end else if (index_in == `FPIS_IDX_TEMP_STATUS) begin
			s_nxt.hit = (sub_in <= 8'h04);
			if (sub_in == `FPIS_SUB_COUNT) begin
				s_nxt.data = {8'h00, `FPIS_TEMP_COUNT};
			end else if (s_nxt.hit) begin
				// 2-bit wrap keeps subindex 4 on word 3
				s_nxt.data = temp_words_in[{2'(sub_in[1:0] - 2'd1), 4'h0} +: 16];
			end
		end
	end

	// read data leave through a register
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s_r <= '{hit: 1'b0, data: 16'h0000};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hit_out  = s_r.hit;
	assign data_out = s_r.data;
endmodule

// *** verilog/fpis_defs.svh ***
`ifndef FPIS_DEFS_SVH
`define FPIS_DEFS_SVH
// object indices and subindices of the object-dictionary port
`define FPIS_IDX_PIN_CFG     16'h2315
`define FPIS_IDX_INPUT_STATE 16'h2311
`define FPIS_IDX_ANALOG_MV   16'h2313
`define FPIS_IDX_ANALOG_RAW  16'h2314
`define FPIS_IDX_TEMP_STATUS 16'h2323
`define FPIS_IDX_ERR_CFG     16'h2321
`define FPIS_IDX_ERR_DELAY   16'h2322
`define FPIS_SUB_COUNT       8'h00
`define FPIS_SUB_ROLE        8'h01
`define FPIS_SUB_OUT_CMD     8'h03
`define FPIS_SUB_LOGICAL     8'h01
`define FPIS_SUB_PHYSICAL    8'h02
`define FPIS_SUB_ERR_MASK    8'h03
`define FPIS_SUB_ERR_DELAY   8'h01
// reset values and entry counts
`define FPIS_PIN_CFG_COUNT   8'h03
`define FPIS_INPUT_COUNT     8'h04
`define FPIS_ANALOG_MV_COUNT 8'h05
`define FPIS_RAW_COUNT       8'h08
`define FPIS_TEMP_COUNT      8'h04
`define FPIS_ROLE_RESET      8'h00
`define FPIS_MASK_RESET      8'hFF
`define FPIS_DELAY_RESET     16'h0000
// field positions in the input bit map
`define FPIS_BIT_ANALOG_PIN  0
`define FPIS_BIT_FAULT_PIN   1
`define FPIS_INPUT_BITS      5
// error flag positions; delayed group is overcurrent, deviation, overvoltage
`define FPIS_ERR_OVERCURRENT 0
`define FPIS_ERR_DEVIATION   1
`define FPIS_ERR_OVERVOLTAGE 2
`define FPIS_ERR_BITS        8
// timing: one error delay unit is 10 ms
`define FPIS_DELAY_UNIT_MS   10
`define FPIS_CLK_KHZ         25000
`define FPIS_UNIT_CYCLES     (`FPIS_DELAY_UNIT_MS * `FPIS_CLK_KHZ)
`endif

// *** verilog/fpis_persist.sv ***
`include "fpis_defs.svh"
// one error flag held back until it persisted the programmed delay
module fpis_persist
	import fpis_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        flag_in,
	input  wire logic        tick_in,
	input  wire logic [15:0] delay_in,
	output logic             show_out
);
	typedef struct packed {
		fpis_fstate_t st;
		logic [15:0]  cnt;
	} fpis_persist_state_t;
	fpis_persist_state_t s_r, s_nxt;

	// counts 10 ms ticks while the flag stays; any drop restarts
	always_comb begin
		s_nxt = s_r;
		unique case (s_r.st)
			FPIS_F_IDLE: begin
				s_nxt.cnt = 16'h0000;
				if (flag_in) begin
					s_nxt.st = (delay_in == 16'h0000) ? FPIS_F_SHOW : FPIS_F_WAIT;
				end
			end
			FPIS_F_WAIT: begin
				if (!flag_in) begin
					s_nxt.st = FPIS_F_IDLE;
				end else if (tick_in) begin
					s_nxt.cnt = s_r.cnt + 16'h0001;
					if (s_r.cnt + 16'h0001 >= delay_in) begin
						s_nxt.st = FPIS_F_SHOW;
					end
				end
			end
			FPIS_F_SHOW: begin
				if (!flag_in) begin
					s_nxt.st = FPIS_F_IDLE;
				end
			end
			default: s_nxt.st = FPIS_F_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s_r <= '{st: FPIS_F_IDLE, cnt: 16'h0000};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign show_out = (s_r.st == FPIS_F_SHOW) && flag_in;
endmodule

// *** verilog/fpis_pkg.sv ***
package fpis_pkg;
	// pin roles as written to the role selector
	typedef enum logic [7:0] {
		FPIS_ROLE_ERROR  = 8'h00,
		FPIS_ROLE_OUTPUT = 8'h02,
		FPIS_ROLE_REF_IN = 8'h04,
		FPIS_ROLE_TARGET = 8'h05
	} fpis_role_t;
	// output command values
	typedef enum logic [7:0] {
		FPIS_CMD_CLEAR  = 8'h00,
		FPIS_CMD_SET    = 8'h01,
		FPIS_CMD_TOGGLE = 8'h02
	} fpis_cmd_t;
	// persistence filter state, gray along idle-wait-show
	typedef enum logic [1:0] {
		FPIS_F_IDLE = 2'b00,
		FPIS_F_WAIT = 2'b01,
		FPIS_F_SHOW = 2'b11
	} fpis_fstate_t;
endpackage

// *** verilog/fpis_top.sv ***
`include "fpis_defs.svh"
// Notes on behaviour
// - role selector picks error, output, input, target
// - general output role starts with pin low
// - output roles pull low or release only
// - error role asserts on any masked error
// - three error kinds shown only after delay
// - commands clear, set or toggle output
// - input role reads pin as digital input
// - target role asserts when target reached
// - next positioning start clears target indication
// - logical word evaluates inputs against polarity
// - physical word shows raw input levels
// - bit map analogue, fault, third, fourth, fifth
// - fault limit functions only in input role
// - signed millivolt readings are read only
// - eight signed raw converter values read only
// - status words readable on sync or request
// - input change never requests process data
// - four read-only temperature words in celsius
// - thresholds mirror overtemperature switch points
module fpis_top
	import fpis_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	// object-dictionary access port
	input  wire logic         od_wr_in,
	input  wire logic         od_rd_in,
	input  wire logic [15:0]  od_index_in,
	input  wire logic [7:0]   od_sub_in,
	input  wire logic [15:0]  od_wdata_in,
	output logic [15:0]       od_rdata_out,
	output logic              od_ack_out,
	output logic              od_err_out,
	// fault pin, open collector
	input  wire logic         fault_pin_in,
	output logic              fault_pin_out,
	output logic              fault_pin_oe_out,
	// other digital inputs, bit map as the status words
	input  wire logic [4:0]   input_levels_in,
	input  wire logic [4:0]   switch_polarity_in,
	input  wire logic         out_cmd_writable_in,
	// drive-side status
	input  wire logic [7:0]   error_flags_in,
	input  wire logic         target_reached_in,
	input  wire logic         position_start_in,
	input  wire logic [127:0] raw_codes_in,
	input  wire logic [79:0]  mv_codes_in,
	input  wire logic [63:0]  temp_words_in,
	// derived outputs
	output logic              fault_ref_input_out,
	output logic              fault_limit_valid_out,
	output logic [4:0]        input_logical_out
);
	// whole block state in one struct
	typedef struct packed {
		fpis_role_t  role;       // pin role selector
		logic        gp_level;   // general output level, 1 = high
		logic        target;     // target reached latch
		logic [7:0]  err_mask;   // per-error pin mask
		logic [15:0] err_delay;  // persistence, 10 ms units
		logic [17:0] tick_cnt;   // 10 ms prescaler
		logic        tick;       // 10 ms tick pulse
		logic        pin_low;    // pin pulled low
		logic [4:0]  phys;       // sampled input levels
		logic [4:0]  logic_word; // polarity evaluated levels
		logic        ack;
		logic        err;
		logic [15:0] rdata;
		logic        rd_bank;    // answer comes from the bank
	} fpis_state_t;
	fpis_state_t s_r, s_nxt;

	logic [2:0]  err_shown;  // filtered delayed errors
	logic        bank_hit;   // bank decode result
	logic [15:0] bank_data;  // bank read word
	logic [4:0]  raw_inputs; // all five inputs with fault pin
	logic        err_active; // masked error present

	// the delayed group passes through persistence filters
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_persist
			fpis_persist u_persist (
				.clk_in   (clk_in),
				.rst_b_in (rst_b_in),
				.flag_in  (error_flags_in[g]),
				.tick_in  (s_r.tick),
				.delay_in (s_r.err_delay),
				.show_out (err_shown[g])
			);
		end
	endgenerate

	// analogue and temperature words
	fpis_bank u_bank (
		.clk_in        (clk_in),
		.rst_b_in      (rst_b_in),
		.raw_codes_in  (raw_codes_in),
		.mv_codes_in   (mv_codes_in),
		.temp_words_in (temp_words_in),
		.index_in      (od_index_in),
		.sub_in        (od_sub_in),
		.hit_out       (bank_hit),
		.data_out      (bank_data)
	);

	// fault pin reads into bit 1 of the input map
	always_comb begin
		raw_inputs = input_levels_in;
		raw_inputs[`FPIS_BIT_FAULT_PIN] = fault_pin_in;
	end

	// undelayed errors go straight through, delayed ones filtered
	always_comb begin
		err_active = |({error_flags_in[7:3], err_shown} & s_r.err_mask);
	end

	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.err = 1'b0;
		s_nxt.rd_bank = 1'b0;
		// 10 ms prescaler
		s_nxt.tick = 1'b0;
		if (s_r.tick_cnt == 18'(`FPIS_UNIT_CYCLES - 1)) begin
			s_nxt.tick_cnt = 18'h00000;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.tick_cnt = s_r.tick_cnt + 18'h00001;
		end
		// input sampling and polarity evaluation
		s_nxt.phys = raw_inputs;
		s_nxt.logic_word = ~(raw_inputs ^ switch_polarity_in);
		// target latch: start wins, it begins a new move
		if (position_start_in) begin
			s_nxt.target = 1'b0;
		end else if (target_reached_in) begin
			s_nxt.target = 1'b1;
		end
		// writes
		if (od_wr_in) begin
			s_nxt.ack = 1'b1;
			if (od_index_in == `FPIS_IDX_PIN_CFG && od_sub_in == `FPIS_SUB_ROLE) begin
				unique case (od_wdata_in[7:0])
					8'h00, 8'h02, 8'h04, 8'h05: begin
						s_nxt.role = fpis_role_t'(od_wdata_in[7:0]);
						// entering output role starts low
						s_nxt.gp_level = 1'b0;
					end
					default: s_nxt.err = 1'b1; // unsupported role value
				endcase
			end else if (od_index_in == `FPIS_IDX_PIN_CFG && od_sub_in == `FPIS_SUB_OUT_CMD) begin
				// commands act only in output role and when writable
				if (!out_cmd_writable_in || s_r.role != FPIS_ROLE_OUTPUT) begin
					s_nxt.err = 1'b1;
				end else begin
					unique case (od_wdata_in[7:0])
						8'h00: s_nxt.gp_level = 1'b0;
						8'h01: s_nxt.gp_level = 1'b1;
						8'h02: s_nxt.gp_level = ~s_r.gp_level;
						default: s_nxt.err = 1'b1;
					endcase
				end
			end else if (od_index_in == `FPIS_IDX_ERR_CFG && od_sub_in == `FPIS_SUB_ERR_MASK) begin
				s_nxt.err_mask = od_wdata_in[7:0];
			end else if (od_index_in == `FPIS_IDX_ERR_DELAY && od_sub_in == `FPIS_SUB_ERR_DELAY) begin
				s_nxt.err_delay = od_wdata_in;
			end else begin
				s_nxt.err = 1'b1; // read-only or unknown entry
			end
		end else if (od_rd_in) begin
			// plain reads; status words readable whenever polled
			s_nxt.ack = 1'b1;
			s_nxt.rdata = 16'h0000;
			if (od_index_in == `FPIS_IDX_PIN_CFG) begin
				unique case (od_sub_in)
					`FPIS_SUB_COUNT:   s_nxt.rdata = {8'h00, `FPIS_PIN_CFG_COUNT};
					`FPIS_SUB_ROLE:    s_nxt.rdata = {8'h00, s_r.role};
					`FPIS_SUB_OUT_CMD: s_nxt.rdata = {15'h0000, s_r.gp_level};
					default:           s_nxt.err = 1'b1;
				endcase
			end else if (od_index_in == `FPIS_IDX_INPUT_STATE) begin
				unique case (od_sub_in)
					`FPIS_SUB_COUNT:    s_nxt.rdata = {8'h00, `FPIS_INPUT_COUNT};
					`FPIS_SUB_LOGICAL:  s_nxt.rdata = {11'h000, s_r.logic_word};
					`FPIS_SUB_PHYSICAL: s_nxt.rdata = {11'h000, s_r.phys};
					default:            s_nxt.err = 1'b1;
				endcase
			end else if (od_index_in == `FPIS_IDX_ERR_CFG && od_sub_in == `FPIS_SUB_ERR_MASK) begin
				s_nxt.rdata = {8'h00, s_r.err_mask};
			end else if (od_index_in == `FPIS_IDX_ERR_DELAY && od_sub_in == `FPIS_SUB_ERR_DELAY) begin
				s_nxt.rdata = s_r.err_delay;
			end else begin
				// bank answers in the same cycle from its own register
				s_nxt.rd_bank = 1'b1;
			end
		end
		// open collector: only ever pull low
		unique case (s_r.role)
			FPIS_ROLE_ERROR:  s_nxt.pin_low = err_active;
			FPIS_ROLE_OUTPUT: s_nxt.pin_low = ~s_nxt.gp_level; // low level means pulled
			FPIS_ROLE_TARGET: s_nxt.pin_low = s_nxt.target;
			default:          s_nxt.pin_low = 1'b0; // input role releases
		endcase
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s_r <= '{role: FPIS_ROLE_ERROR, gp_level: 1'b0, target: 1'b0,
				err_mask: `FPIS_MASK_RESET, err_delay: `FPIS_DELAY_RESET,
				tick_cnt: 18'h00000, tick: 1'b0, pin_low: 1'b0, phys: 5'h00,
				logic_word: 5'h00, ack: 1'b0, err: 1'b0, rdata: 16'h0000,
				rd_bank: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// read answer; bank miss flags an unknown entry
	always_comb begin
		od_ack_out   = s_r.ack;
		od_rdata_out = s_r.rd_bank ? bank_data : s_r.rdata;
		od_err_out   = s_r.err | (s_r.rd_bank & ~bank_hit);
	end

	// pin drives only low, and only while enabled
	assign fault_pin_out    = 1'b0;
	assign fault_pin_oe_out = s_r.pin_low;
	// limit or index use of the fault pin only in input role
	assign fault_ref_input_out   = (s_r.role == FPIS_ROLE_REF_IN) & s_r.logic_word[`FPIS_BIT_FAULT_PIN];
	assign fault_limit_valid_out = (s_r.role == FPIS_ROLE_REF_IN);
	// no change-triggered transmit request exists here
	assign input_logical_out = s_r.logic_word;
endmodule
